// ---- lfs_pkg.sv ----
/*
 * lfs_pkg: constants, register map and carrier types of the LED driver
 * fault supervisor. Assumes a single 250 MHz clock.
 */
package lfs_pkg;
	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 4;
	localparam int OPEN_DEB_NS   = 4800;
	localparam int SHORT_DEB_NS  = 9000;
	localparam int OV_TIMEOUT_MS = 70;
	localparam int RESTART_US    = 1000;
	localparam int CNT_W         = 25;
	localparam int DEB_W         = 12;
	// longest times round down
	localparam logic [DEB_W-1:0] OPEN_DEB_CYC  = DEB_W'(OPEN_DEB_NS / CLK_PERIOD_NS);
	localparam logic [DEB_W-1:0] SHORT_DEB_CYC = DEB_W'(SHORT_DEB_NS / CLK_PERIOD_NS);
	localparam logic [CNT_W-1:0] OV_TIMEOUT_CYC_DEF = CNT_W'(OV_TIMEOUT_MS * 1000000 / CLK_PERIOD_NS);
	localparam logic [CNT_W-1:0] RESTART_CYC_DEF    = CNT_W'(RESTART_US * 1000 / CLK_PERIOD_NS);
	localparam logic [7:0]       RAMP_TICK_CYC      = 8'hFF;
	localparam logic [7:0]       RAMP_FULL          = 8'hFF;

	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam int          ADDR_W         = 5;
	localparam logic [4:0]  OFF_STATUS     = 5'h00;
	localparam logic [4:0]  OFF_IRQ_STATUS = 5'h04;
	localparam logic [4:0]  OFF_IRQ_CLEAR  = 5'h08;
	localparam logic [4:0]  OFF_IRQ_ENABLE = 5'h0C;
	localparam logic [4:0]  OFF_CTRL       = 5'h10;
	localparam logic [0:0]  CTRL_RESET     = 1'h1;
	localparam int          EV_W           = 5;
	localparam int          EV_SHORT       = 0;
	localparam int          EV_OPEN        = 1;
	localparam int          EV_OVERVOLT    = 2;
	localparam int          EV_OVERTEMP    = 3;
	localparam int          EV_UNUSED      = 4;
	localparam logic [1:0]  RESP_OKAY      = 2'h0;
	localparam logic [1:0]  RESP_SLVERR    = 2'h2;

	typedef enum logic [1:0] {ST_SHUTDOWN, ST_STARTUP, ST_RUN, ST_OV_OFF} lfs_state_type;

	// analog comparator outputs, synchronous to aclk
	typedef struct packed {
		logic       uvlo;
		logic       temp_trip;
		logic       temp_release;
		logic       coil_limit_hit;
		logic       rail_at_open_check;
		logic       rail_at_clamp;
		logic [2:0] below_short;
		logic [2:0] headroom_low;
		logic [2:0] tied_to_rail;
	} lfs_sense_type;

	typedef struct packed {
		logic       boost_enable;
		logic       switch_allow;
		logic [2:0] source_enable;
		logic [7:0] ramp_level;
	} lfs_drive_type;
endpackage : lfs_pkg

// ---- lfs_top.sv ----
/*
 * lfs_top: enable-pin sequencing, soft ramp, string fault detection,
 * protection and an AXI4-Lite register slave. Assumes all comparator
 * inputs and the enable pin are already synchronous to aclk.
 */
// The implementer's own choices: the AXI4-Lite interface to the registers and the register addresses.
// Functional notes
// pin high enables boost and all sources
// soft ramp completes even with short PWM
// tied outputs found at enable rise, disabled
// short after startup: low for debounce time
// open: rail at check, headroom low, debounced
// no open if coil limit came first
// disable only the failing string
// string errors held until shutdown clears them
// rail at clamp beyond timeout stops converter
// host holds pin low past restart timeout
// coil limit ends every switching cycle
// overtemperature stops, restarts after hysteresis
// undervoltage forces shutdown regardless of pin
// open debounce at most 4.8 us
// short debounce up to 9.0 us, longer
// debounces count consecutive cycles, restart on drop
// detection gated by startup done, enabled strings
`timescale 1ns/1ps
module lfs_top import lfs_pkg::*; #(
	parameter logic [CNT_W-1:0] OV_TIMEOUT_CYC = OV_TIMEOUT_CYC_DEF,
	parameter logic [CNT_W-1:0] RESTART_CYC    = RESTART_CYC_DEF
) (
	// clock and reset
	input  wire logic              aclk,
	input  wire logic              aresetn,
	// axi4-lite slave
	input  wire logic [ADDR_W-1:0] awaddr,
	input  wire logic              awvalid,
	output logic                   awready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	input  wire logic              wvalid,
	output logic                   wready,
	output logic [1:0]             bresp,
	output logic                   bvalid,
	input  wire logic              bready,
	input  wire logic [ADDR_W-1:0] araddr,
	input  wire logic              arvalid,
	output logic                   arready,
	output logic [31:0]            rdata,
	output logic [1:0]             rresp,
	output logic                   rvalid,
	input  wire logic              rready,
	// enable pin and comparators
	input  wire logic              enable_pin,
	input  wire lfs_sense_type     sense,
	// converter and sources
	output lfs_drive_type          drive,
	output logic                   irq
);
	// ------------------------------------------------------------
	// sequencer state
	// ------------------------------------------------------------
	lfs_state_type    state_reg, state_next;
	logic             en_d_reg;
	logic [CNT_W-1:0] low_cnt_reg, ov_cnt_reg;
	logic [7:0]       tick_cnt_reg, ramp_reg;
	logic             ot_stop_reg, limit_first_reg;
	logic [2:0]       short_reg, open_reg, unused_reg;
	logic [0:0]       ctrl_reg;
	logic [EV_W-1:0]  irq_status_reg, irq_enable_reg;
	lfs_drive_type    drive_reg;

	wire en_rise     = enable_pin & ~en_d_reg;
	wire low_expired = low_cnt_reg >= RESTART_CYC;
	wire ov_expired  = ov_cnt_reg >= OV_TIMEOUT_CYC;
	wire ramp_tick   = tick_cnt_reg == RAMP_TICK_CYC;
	wire active      = (state_reg == ST_STARTUP) | (state_reg == ST_RUN);
	wire in_shutdown = state_reg == ST_SHUTDOWN;
	wire [2:0] fault = short_reg | open_reg | unused_reg;
	wire [2:0] src_on = {3{enable_pin & active & ~ot_stop_reg & ~sense.uvlo}} & ~fault;
	wire detect_on   = (state_reg == ST_RUN) & ctrl_reg[0] & enable_pin;
	wire [2:0] short_set, open_set;

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_SHUTDOWN: if (en_rise) state_next = ST_STARTUP;
			ST_STARTUP: begin
				// ramp only advances while the pin is high and is kept while low
				if (low_expired) state_next = ST_SHUTDOWN;
				else if (ramp_reg == RAMP_FULL) state_next = ST_RUN;
			end
			ST_RUN: begin
				if (low_expired) state_next = ST_SHUTDOWN;
				else if (ov_expired) state_next = ST_OV_OFF;
			end
			ST_OV_OFF: if (low_expired) state_next = ST_SHUTDOWN;
			default: state_next = ST_SHUTDOWN;
		endcase
		if (sense.uvlo) state_next = ST_SHUTDOWN;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg <= ST_SHUTDOWN;
			en_d_reg  <= 1'b0;
		end else begin
			state_reg <= state_next;
			en_d_reg  <= enable_pin;
		end
	end

	// ------------------------------------------------------------
	// timers
	// ------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			low_cnt_reg <= '0;
			ov_cnt_reg  <= '0;
		end else begin
			low_cnt_reg <= enable_pin ? '0 : (low_expired ? low_cnt_reg : low_cnt_reg + 1'b1);
			// restarts whenever the rail leaves the clamp
			ov_cnt_reg  <= (sense.rail_at_clamp && state_reg == ST_RUN) ?
				(ov_expired ? ov_cnt_reg : ov_cnt_reg + 1'b1) : '0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || state_reg != ST_STARTUP) begin
			tick_cnt_reg <= '0;
			ramp_reg     <= '0;
		end else if (enable_pin && !ot_stop_reg) begin
			tick_cnt_reg <= ramp_tick ? '0 : tick_cnt_reg + 1'b1;
			if (ramp_tick && ramp_reg != RAMP_FULL) ramp_reg <= ramp_reg + 1'b1;
		end
	end

	// ------------------------------------------------------------
	// protection latches
	// ------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ot_stop_reg     <= 1'b0;
			limit_first_reg <= 1'b0;
		end else begin
			if (sense.temp_trip) ot_stop_reg <= 1'b1;
			else if (sense.temp_release) ot_stop_reg <= 1'b0;
			// a limit hit below the check level blocks open detection until the pin drops
			if (!enable_pin || in_shutdown) limit_first_reg <= 1'b0;
			else if (sense.coil_limit_hit && !sense.rail_at_open_check) limit_first_reg <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// per-string debounce
	// ------------------------------------------------------------
	for (genvar i = 0; i < 3; i++) begin : g_str
		logic [DEB_W-1:0] sh_cnt_reg, op_cnt_reg;
		wire sh_cond = detect_on & src_on[i] & sense.below_short[i];
		wire op_cond = detect_on & src_on[i] & sense.rail_at_open_check & sense.headroom_low[i]
			& ~limit_first_reg;
		assign short_set[i] = sh_cond & (sh_cnt_reg == SHORT_DEB_CYC - 1'b1);
		assign open_set[i]  = op_cond & (op_cnt_reg == OPEN_DEB_CYC - 1'b1);
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				sh_cnt_reg <= '0;
				op_cnt_reg <= '0;
			end else begin
				sh_cnt_reg <= (sh_cond && !short_set[i]) ? sh_cnt_reg + 1'b1 : '0;
				op_cnt_reg <= (op_cond && !open_set[i]) ? op_cnt_reg + 1'b1 : '0;
			end
		end
	end

	wire [2:0] tied_set = {3{en_rise & ~sense.uvlo}} & sense.tied_to_rail;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			short_reg  <= '0;
			open_reg   <= '0;
			unused_reg <= '0;
		end else if (in_shutdown) begin
			// the rise that leaves shutdown must still latch the tied outputs
			short_reg  <= '0;
			open_reg   <= '0;
			unused_reg <= tied_set;
		end else begin
			short_reg  <= short_reg | short_set;
			open_reg   <= open_reg | open_set;
			unused_reg <= unused_reg | tied_set;
		end
	end
	// unused outputs must be caught on the rising edge that leaves shutdown
	wire [2:0] tied_boot = (in_shutdown) ? tied_set : 3'h0;

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	wire boost_on = enable_pin & active & ~ot_stop_reg & ~sense.uvlo;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			drive_reg <= '0;
		end else begin
			drive_reg.boost_enable  <= boost_on;
			drive_reg.switch_allow  <= boost_on & ~sense.coil_limit_hit;
			drive_reg.source_enable <= src_on & ~(tied_set | tied_boot);
			drive_reg.ramp_level    <= (state_reg == ST_RUN) ? RAMP_FULL : ramp_reg;
		end
	end
	assign drive = drive_reg;

	// ------------------------------------------------------------
	// interrupt status
	// ------------------------------------------------------------
	logic             ot_d_reg;
	logic [EV_W-1:0]  irq_clear;
	// only a newly found tied output is an event, not every pwm rise
	wire [EV_W-1:0] events = {|(tied_set & ~unused_reg), ot_stop_reg & ~ot_d_reg,
		state_next == ST_OV_OFF && state_reg == ST_RUN, |open_set, |short_set};

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ot_d_reg       <= 1'b0;
			irq_status_reg <= '0;
		end else begin
			ot_d_reg       <= ot_stop_reg;
			// a new event wins over a clear in the same cycle
			irq_status_reg <= (irq_status_reg & ~irq_clear) | events;
		end
	end
	assign irq = |(irq_status_reg & irq_enable_reg);

	// ------------------------------------------------------------
	// axi4-lite slave
	// ------------------------------------------------------------
	logic              aw_held_reg, w_held_reg, bvalid_reg, rvalid_reg;
	logic [ADDR_W-1:0] aw_addr_reg;
	logic [31:0]       w_data_reg, rdata_reg;
	logic [3:0]        w_strb_reg;
	logic [1:0]        bresp_reg, rresp_reg;

	assign awready = ~aw_held_reg & ~bvalid_reg;
	assign wready  = ~w_held_reg & ~bvalid_reg;
	assign arready = ~rvalid_reg;
	wire do_write  = aw_held_reg & w_held_reg & ~bvalid_reg;
	wire wr_lane0  = do_write & w_strb_reg[0];
	wire wa_ok     = aw_addr_reg == OFF_STATUS || aw_addr_reg == OFF_IRQ_STATUS ||
		aw_addr_reg == OFF_IRQ_CLEAR || aw_addr_reg == OFF_IRQ_ENABLE || aw_addr_reg == OFF_CTRL;
	assign irq_clear = (wr_lane0 && aw_addr_reg == OFF_IRQ_CLEAR) ? w_data_reg[EV_W-1:0] : '0;

	logic [31:0] rd_mux;
	logic        rd_ok;
	always_comb begin
		rd_ok  = 1'b1;
		rd_mux = 32'h0;
		case (araddr)
			OFF_STATUS:     rd_mux = {19'h0, open_reg, short_reg, unused_reg, ot_stop_reg, state_reg == ST_RUN, state_reg};
			OFF_IRQ_STATUS: rd_mux = {27'h0, irq_status_reg};
			OFF_IRQ_CLEAR:  rd_mux = 32'h0;
			OFF_IRQ_ENABLE: rd_mux = {27'h0, irq_enable_reg};
			OFF_CTRL:       rd_mux = {31'h0, ctrl_reg};
			default:        rd_ok  = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_reg <= 1'b0;
			w_held_reg  <= 1'b0;
			bvalid_reg  <= 1'b0;
			aw_addr_reg <= '0;
			w_data_reg  <= '0;
			w_strb_reg  <= '0;
			bresp_reg   <= RESP_OKAY;
		end else begin
			if (awvalid && awready) begin
				aw_held_reg <= 1'b1;
				aw_addr_reg <= awaddr;
			end
			if (wvalid && wready) begin
				w_held_reg <= 1'b1;
				w_data_reg <= wdata;
				w_strb_reg <= wstrb;
			end
			if (do_write) begin
				aw_held_reg <= 1'b0;
				w_held_reg  <= 1'b0;
				bvalid_reg  <= 1'b1;
				bresp_reg   <= wa_ok ? RESP_OKAY : RESP_SLVERR;
			end else if (bvalid_reg && bready) begin
				bvalid_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_reg       <= CTRL_RESET;
			irq_enable_reg <= '0;
		end else if (wr_lane0) begin
			if (aw_addr_reg == OFF_CTRL) ctrl_reg <= w_data_reg[0:0];
			if (aw_addr_reg == OFF_IRQ_ENABLE) irq_enable_reg <= w_data_reg[EV_W-1:0];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_reg <= 1'b0;
			rdata_reg  <= '0;
			rresp_reg  <= RESP_OKAY;
		end else if (arvalid && arready) begin
			rvalid_reg <= 1'b1;
			rdata_reg  <= rd_mux;
			rresp_reg  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid_reg && rready) begin
			rvalid_reg <= 1'b0;
		end
	end

	assign bvalid = bvalid_reg;
	assign bresp  = bresp_reg;
	assign rvalid = rvalid_reg;
	assign rdata  = rdata_reg;
	assign rresp  = rresp_reg;
endmodule : lfs_top

// ---- lfs_monitor.sv ----
/*
 * lfs_monitor: port-level assertions for lfs_top, attached by bind.
 * Assumes the single aclk domain and the synchronous aresetn.
 */
`timescale 1ns/1ps
module lfs_monitor import lfs_pkg::*; (
	// clock and reset
	input wire logic          aclk,
	input wire logic          aresetn,
	// register bus
	input wire logic          awvalid,
	input wire logic          awready,
	input wire logic          wvalid,
	input wire logic          wready,
	input wire logic          bvalid,
	input wire logic          bready,
	input wire logic [1:0]    bresp,
	input wire logic          arvalid,
	input wire logic          arready,
	input wire logic          rvalid,
	input wire logic          rready,
	input wire logic [31:0]   rdata,
	// pin, comparators, drive
	input wire logic          enable_pin,
	input wire lfs_sense_type sense,
	input wire lfs_drive_type drive
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	a_pin_low_off: assert property (!enable_pin [*2] |=> drive.source_enable == 3'h0)
		else $error("sources on while pin low");
	a_ramp_single_step: assert property (drive.ramp_level != $past(drive.ramp_level) && drive.ramp_level != 8'h00
		|-> drive.ramp_level == $past(drive.ramp_level) + 8'h01) else $error("ramp jumped");
	a_coil_cuts_cycle: assert property (sense.coil_limit_hit |=> !drive.switch_allow)
		else $error("switching not ended at coil limit");
	a_temp_stops: assert property (sense.temp_trip [*2] |=> !drive.boost_enable && drive.source_enable == 3'h0)
		else $error("converter runs while hot");
	a_uvlo_holds_off: assert property (sense.uvlo [*2] |=> !drive.boost_enable && drive.source_enable == 3'h0)
		else $error("converter runs in undervoltage");
	a_write_answered: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
		else $error("write response missing");
	a_read_answered: assert property (arvalid && arready |=> rvalid) else $error("read data missing");
	a_resp_held: assert property (bvalid && !bready |=> bvalid && $stable(bresp)) else $error("write response dropped");
	a_rdata_held: assert property (rvalid && !rready |=> rvalid && $stable(rdata)) else $error("read data dropped");
	a_busy_refuses: assert property (bvalid |-> !awready && !wready) else $error("write taken while busy");
endmodule : lfs_monitor

bind lfs_top lfs_monitor i_mon (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
	.wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
	.arready(arready), .rvalid(rvalid), .rready(rready), .rdata(rdata), .enable_pin(enable_pin),
	.sense(sense), .drive(drive));

// ---- lfs_host_model.sv ----
/*
 * lfs_host_model: host driving the enable pin, steady or as a PWM.
 * Assumes the bench sets the pulse shape; hi_cyc of zero holds the pin low.
 */
`timescale 1ns/1ps
module lfs_host_model (
	// clock and reset
	input wire logic       aclk,
	input wire logic       aresetn,
	// pulse shape in cycles, lo_cyc zero means steady high unless hi_cyc is zero
	input wire logic [7:0] hi_cyc,
	input wire logic [7:0] lo_cyc,
	// enable pin
	output logic           enable_pin
);
	logic [7:0] cnt_reg;
	always_ff @(posedge aclk) begin
		if (!aresetn || hi_cyc == 8'h00) begin
			enable_pin <= 1'b0;
			cnt_reg    <= 8'h00;
		end else if (lo_cyc == 8'h00) begin
			enable_pin <= 1'b1;
		end else if (cnt_reg == 8'h00) begin
			enable_pin <= !enable_pin;
			cnt_reg    <= (enable_pin ? lo_cyc : hi_cyc) - 8'h01;
		end else begin
			cnt_reg <= cnt_reg - 8'h01;
		end
	end
endmodule : lfs_host_model

// ---- tb_top.sv ----
/*
 * tb_top: self-checking bench for lfs_top with an AXI4-Lite master.
 * Assumes shortened overvoltage and restart counts set below.
 */
`timescale 1ns/1ps
module tb_top import lfs_pkg::*;;
	logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, enable_pin, irq;
	logic [4:0] awaddr, araddr;
	logic [31:0] wdata, rdata, d;
	logic [1:0] bresp, rresp, r;
	logic [7:0] hi, lo;
	lfs_sense_type sense;
	lfs_drive_type drive;
	int cycles, miscompares, checks_done;
	lfs_top #(.OV_TIMEOUT_CYC(25'h00000C8), .RESTART_CYC(25'h0000032)) i_dut (.aclk(aclk), .aresetn(aresetn),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.enable_pin(enable_pin), .sense(sense), .drive(drive), .irq(irq));
	lfs_host_model i_host (.aclk(aclk), .aresetn(aresetn), .hi_cyc(hi), .lo_cyc(lo), .enable_pin(enable_pin));
	always #2 aclk = !aclk;
	// the ramp alone takes some 70k cycles under the PWM used here
	always @(posedge aclk) begin
		cycles++;
		if (cycles == 95000) begin
			miscompares++;
			wrap_up();
		end
	end
	task automatic wrap_up;
		$display("checks %0d miscompares %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : wrap_up
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic axi_wr(input logic [4:0] a, input logic [31:0] v);
		@(posedge aclk);
		awaddr  <= a;
		wdata   <= v;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		bready <= 1'b0;
		chk(32'(bresp), 32'(RESP_OKAY));
	endtask : axi_wr
	task automatic axi_rd(input logic [4:0] a);
		@(posedge aclk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		rready <= 1'b0;
		d = rdata;
		r = rresp;
	endtask : axi_rd
	task automatic rd_chk(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
		axi_rd(a);
		chk(d & m, e);
	endtask : rd_chk
	// ------------------------------------------------------------
	// test sequence
	// ------------------------------------------------------------
	initial begin
		{aclk, aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, wdata, hi, lo, miscompares, checks_done} = '0;
		sense = '0;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		rd_chk(OFF_CTRL, 32'h1, 32'h1);
		rd_chk(OFF_IRQ_ENABLE, 32'h1F, 32'h0);
		rd_chk(OFF_STATUS, 32'h3, 32'h0);
		axi_rd(5'h14);
		chk({d[31:2], r}, {30'h0, RESP_SLVERR});
		axi_wr(OFF_IRQ_ENABLE, 32'h1F);
		sense.tied_to_rail <= 3'h4;
		hi <= 8'h0F;
		lo <= 8'h01;
		repeat (40) @(posedge aclk);
		rd_chk(OFF_STATUS, 32'h70, 32'h40);
		chk(32'(irq), 32'h1);
		axi_wr(OFF_IRQ_CLEAR, 32'h10);
		chk(32'(irq), 32'h0);
		wait (drive.ramp_level === RAMP_FULL);
		lo <= 8'h00;
		repeat (4) @(posedge aclk);
		rd_chk(OFF_STATUS, 32'h3, 32'h2);
		chk(32'(drive.source_enable), 32'h3);
		axi_wr(OFF_CTRL, 32'h0);
		rd_chk(OFF_CTRL, 32'h1, 32'h0);
		sense.below_short <= 3'h1;
		repeat (2260) @(posedge aclk);
		sense.below_short <= 3'h0;
		@(posedge aclk);
		chk(32'(drive.source_enable), 32'h3);
		axi_wr(OFF_CTRL, 32'h1);
		for (int i = 0; i < 3; i++) begin
			sense.below_short <= (i < 2) ? 3'h1 : 3'h5;
			repeat ((i < 2) ? 2249 : 2260) @(posedge aclk);
			sense.below_short <= 3'h0;
			@(posedge aclk);
		end
		repeat (3) @(posedge aclk);
		chk(32'(drive.source_enable), 32'h2);
		sense.coil_limit_hit <= 1'b1;
		@(posedge aclk);
		sense.coil_limit_hit     <= 1'b0;
		sense.rail_at_open_check <= 1'b1;
		sense.headroom_low       <= 3'h2;
		repeat (1300) @(posedge aclk);
		chk(32'(drive.source_enable), 32'h2);
		sense.headroom_low <= 3'h0;
		hi <= 8'h00;
		repeat (3) @(posedge aclk);
		hi <= 8'h01;
		repeat (4) @(posedge aclk);
		sense.headroom_low <= 3'h2;
		repeat (1205) @(posedge aclk);
		chk(32'(drive.source_enable), 32'h0);
		sense.headroom_low       <= 3'h0;
		sense.rail_at_open_check <= 1'b0;
		rd_chk(OFF_STATUS, 32'h1F80, 32'h0880);
		rd_chk(OFF_IRQ_STATUS, 32'h3, 32'h3);
		sense.rail_at_clamp <= 1'b1;
		repeat (210) @(posedge aclk);
		sense.rail_at_clamp <= 1'b0;
		chk(32'(drive.boost_enable), 32'h0);
		rd_chk(OFF_STATUS, 32'h3, 32'h3);
		hi <= 8'h00;
		repeat (60) @(posedge aclk);
		rd_chk(OFF_STATUS, 32'h1FF3, 32'h0);
		axi_wr(OFF_IRQ_ENABLE, 32'h0);
		chk(32'(irq), 32'h0);
		axi_wr(OFF_IRQ_ENABLE, 32'h1F);
		chk(32'(irq), 32'h1);
		axi_wr(OFF_IRQ_CLEAR, 32'h1F);
		chk(32'(irq), 32'h0);
		hi <= 8'h01;
		repeat (10) @(posedge aclk);
		chk(32'(drive.boost_enable), 32'h1);
		sense.temp_trip <= 1'b1;
		repeat (3) @(posedge aclk);
		sense.temp_trip <= 1'b0;
		repeat (5) @(posedge aclk);
		chk(32'(drive.boost_enable), 32'h0);
		sense.temp_release <= 1'b1;
		repeat (5) @(posedge aclk);
		sense.temp_release <= 1'b0;
		chk(32'(drive.boost_enable), 32'h1);
		sense.uvlo <= 1'b1;
		repeat (4) @(posedge aclk);
		chk(32'(drive.boost_enable), 32'h0);
		rd_chk(OFF_STATUS, 32'h3, 32'h0);
		wrap_up();
	end
endmodule : tb_top
